/* File: core/pcsu_pkg.sv */
// package of constants and types for the procedure call stack unit
package pcsu_pkg;

   // ***************************************************************
   // widths and register stack
   // ***************************************************************
   localparam int          WORD_W        = 16;
   localparam int          RS_DEPTH      = 8;
   localparam int          RP_W          = 3;
   localparam int          STEP_W        = 4;
   localparam logic [2:0]  RP_EMPTY      = 3'h7;  // pointer value of an empty register stack
   localparam logic [2:0]  RP_FIRST      = 3'h0;

   // ***************************************************************
   // stack marker and addressing
   // ***************************************************************
   localparam logic [15:0] MARKER_WORDS  = 16'h0003;
   localparam logic [15:0] MARKER_P_OFS  = 16'h0002;  // saved P sits two below the marker top
   localparam logic [15:0] ONE_WORD      = 16'h0001;
   localparam logic [3:0]  MARKER_STEPS  = 4'h3;
   localparam logic [3:0]  ONE_STEP      = 4'h1;
   localparam logic [3:0]  STEP_ENV      = 4'h1;
   localparam logic [3:0]  STEP_L        = 4'h2;

   // operand fields: rp after push or pop, word count less one, mode, displacement
   localparam int          OPND_RP_HI    = 8;
   localparam int          OPND_RP_LO    = 6;
   localparam int          OPND_CNT_HI   = 2;
   localparam int          OPND_CNT_LO   = 0;
   localparam int          OPND_MODE_HI  = 6;
   localparam int          OPND_MODE_LO  = 5;
   localparam int          OPND_DISP_HI  = 4;
   localparam int          OPND_DISP_LO  = 0;

   // memory addressing modes carried in the operand of loads and stores
   localparam logic [1:0]  MODE_L_PLUS   = 2'h0;
   localparam logic [1:0]  MODE_L_MINUS  = 2'h1;
   localparam logic [1:0]  MODE_S_MINUS  = 2'h2;

   // ***************************************************************
   // logical memory map numbers
   // ***************************************************************
   localparam logic [2:0]  MAP_USER_DATA = 3'h0;
   localparam logic [2:0]  MAP_SYS_DATA  = 3'h1;
   localparam logic [2:0]  MAP_USER_CODE = 3'h2;
   localparam logic [2:0]  MAP_SYS_CODE  = 3'h3;
   localparam logic [2:0]  MAP_USER_LIB  = 3'h4;
   localparam logic [2:0]  MAP_SYS_EXT   = 3'h5;

   // ***************************************************************
   // operations
   // ***************************************************************
   typedef enum logic [3:0] {
      OP_NOP,
      OP_LOAD_IMMEDIATE,
      OP_INTEGER_ADD,
      OP_INTEGER_SUBTRACT,
      OP_INTEGER_MULTIPLY,
      OP_REGSTACK_MOVE,
      OP_MEM_LOAD,
      OP_MEMORY_STORE,
      OP_MEM_PUSH,
      OP_MEM_POP,
      OP_PROCEDURE_CALL,
      OP_PROC_EXIT,
      OP_SUBPROC_BRANCH,
      OP_SUBPROC_RETURN
   } pcsu_op_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ACCESS
   } pcsu_state_t;

endpackage

/* File: core/pcsu_stack_unit.sv */
// procedure call stack unit: register stack, memory stack, markers and subprocedures
//
// Functional notes
// [R1] called procedure starts with empty register stack
// [R2] load advances pointer; first load selects entry zero
// [R3] multiply top two, product lower, pointer back
// [R4] exit drops marker and parameters, keeps result
// [R5] push copies entries to memory, higher on top
// [R6] move operand one copies entry zero to one
// [R7] pop brings top word to highest entry
// [R8] storing last value empties register stack
// [R9] call writes marker one above stack top
// [R10] call raises local base; markers chain environments
// [R11] subprocedure branch bumps S, saves return
// [R12] then jumps self-relative to target
// [R13] subprocedure return loads P, drops S
// [R14] caller encodes return decrement of one or more
// [R15] S-minus mode reaches 32 words below S
// [R16] six segment maps, numbered zero to five
// [R17] L-minus mode reaches 32 words below L
// [R18] after call L and S at marker top
// [R19] exit restores caller L and pre-parameter S
// [R20] system code extension uses map five
// [R21] pointer wraps modulo eight from empty
`timescale 1ns/1ps

module pcsu_stack_unit
(
   input  wire logic              I_REF_CLK,
   input  wire logic              I_RST_N,
   input  wire logic              I_OP_VALID,
   input  wire pcsu_pkg::pcsu_op_t I_OP,
   input  wire logic [15:0]       I_OPERAND,
   input  wire logic [15:0]       I_ENV,
   input  wire logic              I_LS,
   input  wire logic              I_CS,
   input  wire logic              I_DS,
   input  wire logic              I_MEM_ACK,
   input  wire logic [15:0]       I_MEM_RDATA,
   output logic                   O_BUSY,
   output logic                   O_DONE,
   output logic                   O_MEM_REQ,
   output logic                   O_MEM_WE,
   output logic [15:0]            O_MEM_ADDR,
   output logic [15:0]            O_MEM_WDATA,
   output logic [2:0]             O_RP,
   output logic [15:0]            O_TOP,
   output logic [15:0]            O_L,
   output logic [15:0]            O_S,
   output logic [15:0]            O_P,
   output logic [15:0]            O_ENV,
   output logic [2:0]             O_CODE_MAP,
   output logic [2:0]             O_DATA_MAP
);
   import pcsu_pkg::*;

   // ***************************************************************
   // helper functions
   // ***************************************************************

   // effective address of a load or store; both minus modes span disp 0..31
   function automatic logic [15:0] eff_addr(input logic [15:0] opnd, input logic [15:0] l,
                                            input logic [15:0] s);
      logic [15:0] disp;
      disp = {11'h000, opnd[OPND_DISP_HI:OPND_DISP_LO]};
      unique case (opnd[OPND_MODE_HI:OPND_MODE_LO])
         MODE_L_MINUS: eff_addr = l - disp;                        // [R17]
         MODE_S_MINUS: eff_addr = s - disp;                        // [R15]
         default:      eff_addr = l + disp;
      endcase
   endfunction

   // number of memory words an operation moves
   function automatic logic [3:0] mem_steps(input pcsu_op_t op, input logic [15:0] opnd);
      unique case (op)
         OP_MEM_PUSH, OP_MEM_POP:
            mem_steps = {1'b0, opnd[OPND_CNT_HI:OPND_CNT_LO]} + ONE_STEP;
         OP_PROCEDURE_CALL, OP_PROC_EXIT:
            mem_steps = MARKER_STEPS;
         OP_MEM_LOAD, OP_MEMORY_STORE, OP_SUBPROC_BRANCH, OP_SUBPROC_RETURN:
            mem_steps = ONE_STEP;
         default:
            mem_steps = 4'h0;
      endcase
   endfunction

   // ***************************************************************
   // state
   // ***************************************************************
   pcsu_state_t  state_r, state_nxt;
   pcsu_op_t     op_r, op_nxt;
   logic [15:0]  opnd_r, opnd_nxt;
   logic [3:0]   step_r, step_nxt;
   logic [15:0]  regs_r [RS_DEPTH];
   logic [15:0]  regs_nxt [RS_DEPTH];
   logic [2:0]   rp_r, rp_nxt;
   logic [15:0]  l_r, l_nxt, s_r, s_nxt, p_r, p_nxt, env_r, env_nxt;
   logic [15:0]  tmp_p_r, tmp_p_nxt, top_r, top_nxt;
   logic         busy_r, busy_nxt, done_r, done_nxt;
   logic         req_r, req_nxt, we_r, we_nxt;
   logic [15:0]  addr_r, addr_nxt, wdata_r, wdata_nxt;
   logic [2:0]   cmap_r, cmap_nxt, dmap_r, dmap_nxt;

   // access description for the step about to be issued
   pcsu_op_t     acc_op;
   logic [15:0]  acc_opnd;
   logic [3:0]   acc_step;
   logic         acc_we;
   logic [15:0]  acc_addr, acc_wdata;

   // ***************************************************************
   // memory access for one step of a single- or multi-word memory operation
   // ***************************************************************
   always_comb
   begin
      acc_we    = 1'b0;
      acc_addr  = s_r;
      acc_wdata = 16'h0000;
      unique case (acc_op)
         OP_MEM_PUSH:
         begin
            acc_we    = 1'b1;
            acc_addr  = s_r + ONE_WORD + {12'h000, acc_step};          // [R5]
            acc_wdata = regs_r[acc_step[RP_W-1:0]];                    // [R5]
         end
         OP_MEM_POP:
            acc_addr = s_r - {12'h000, acc_step};                      // [R7]
         OP_PROCEDURE_CALL:
         begin
            acc_we   = 1'b1;
            acc_addr = s_r + ONE_WORD + {12'h000, acc_step};           // [R9]
            // marker holds caller P, ENV and L, linking the previous marker
            if (acc_step == STEP_L)
               acc_wdata = l_r;                                        // [R10]
            else if (acc_step == STEP_ENV)
               acc_wdata = I_ENV;                                      // [R10]
            else
               acc_wdata = p_r;
         end
         OP_PROC_EXIT:
            acc_addr = l_r - MARKER_P_OFS + {12'h000, acc_step};
         OP_SUBPROC_BRANCH:
         begin
            acc_we    = 1'b1;
            acc_addr  = s_r + ONE_WORD;                                // [R11]
            acc_wdata = p_r;                                           // [R11]
         end
         OP_SUBPROC_RETURN:
            acc_addr = s_r;                                            // [R13]
         OP_MEM_LOAD:
            acc_addr = eff_addr(acc_opnd, l_r, s_r);
         OP_MEMORY_STORE:
         begin
            acc_we    = 1'b1;
            acc_addr  = eff_addr(acc_opnd, l_r, s_r);
            acc_wdata = regs_r[rp_r];
         end
         default:
            acc_we = 1'b0;
      endcase
   end

   // ***************************************************************
   // sequencer: next values of all state
   // ***************************************************************
   always_comb
   begin
      state_nxt = state_r;
      op_nxt    = op_r;
      opnd_nxt  = opnd_r;
      step_nxt  = step_r;
      regs_nxt  = regs_r;
      rp_nxt    = rp_r;
      l_nxt     = l_r;
      s_nxt     = s_r;
      p_nxt     = p_r;
      env_nxt   = env_r;
      tmp_p_nxt = tmp_p_r;
      busy_nxt  = busy_r;
      done_nxt  = 1'b0;
      req_nxt   = req_r;
      we_nxt    = we_r;
      addr_nxt  = addr_r;
      wdata_nxt = wdata_r;
      acc_op    = op_r;
      acc_opnd  = opnd_r;
      acc_step  = step_r;
      // code map follows LS/CS, data map follows DS
      unique case ({I_LS, I_CS})
         2'b00:   cmap_nxt = MAP_USER_CODE;                            // [R16]
         2'b01:   cmap_nxt = MAP_SYS_CODE;                             // [R16]
         2'b10:   cmap_nxt = MAP_USER_LIB;                             // [R16]
         default: cmap_nxt = MAP_SYS_EXT;                              // [R20]
      endcase
      dmap_nxt = I_DS ? MAP_SYS_DATA : MAP_USER_DATA;                  // [R16]
      unique case (state_r)
         ST_IDLE:
         begin
            if (I_OP_VALID)
            begin
               op_nxt   = I_OP;
               opnd_nxt = I_OPERAND;
               acc_op   = I_OP;
               acc_opnd = I_OPERAND;
               acc_step = 4'h0;
               if (mem_steps(I_OP, I_OPERAND) != 4'h0)
               begin
                  // memory ops hold off new requests until the last word is acked
                  state_nxt = ST_ACCESS;
                  step_nxt  = 4'h0;
                  busy_nxt  = 1'b1;
                  req_nxt   = 1'b1;
                  we_nxt    = acc_we;
                  addr_nxt  = acc_addr;
                  wdata_nxt = acc_wdata;
               end
               else
               begin
                  done_nxt = 1'b1;
                  unique case (I_OP)
                     OP_LOAD_IMMEDIATE:
                     begin
                        rp_nxt           = rp_r + 3'h1;                // [R2] [R21]
                        regs_nxt[rp_nxt] = I_OPERAND;                  // [R2]
                     end
                     OP_INTEGER_ADD:
                     begin
                        regs_nxt[rp_r - 3'h1] = regs_r[rp_r - 3'h1] + regs_r[rp_r];
                        rp_nxt                = rp_r - 3'h1;
                     end
                     OP_INTEGER_SUBTRACT:
                     begin
                        regs_nxt[rp_r - 3'h1] = regs_r[rp_r - 3'h1] - regs_r[rp_r];
                        rp_nxt                = rp_r - 3'h1;
                     end
                     OP_INTEGER_MULTIPLY:
                     begin
                        // only the low word of the product is kept
                        regs_nxt[rp_r - 3'h1] = 16'(regs_r[rp_r - 3'h1] * regs_r[rp_r]); // [R3]
                        rp_nxt                = rp_r - 3'h1;                         // [R3]
                     end
                     OP_REGSTACK_MOVE:
                        regs_nxt[I_OPERAND[RP_W-1:0]] = regs_r[rp_r];  // [R6]
                     default:
                        rp_nxt = rp_r;
                  endcase
               end
            end
         end
         ST_ACCESS:
         begin
            if (I_MEM_ACK)
            begin
               // capture read data of the step just finished
               unique case (op_r)
                  OP_MEM_POP:
                     regs_nxt[3'(mem_steps(op_r, opnd_r) - ONE_STEP - step_r)] =
                        I_MEM_RDATA;                                   // [R7]
                  OP_MEM_LOAD:
                  begin
                     rp_nxt           = rp_r + 3'h1;                   // [R2] [R21]
                     regs_nxt[rp_nxt] = I_MEM_RDATA;
                  end
                  OP_PROC_EXIT:
                     if (step_r == 4'h0)
                        tmp_p_nxt = I_MEM_RDATA;
                     else if (step_r == STEP_ENV)
                        env_nxt = I_MEM_RDATA;
                  default:
                     tmp_p_nxt = tmp_p_r;
               endcase
               if (step_r + ONE_STEP < mem_steps(op_r, opnd_r))
               begin
                  step_nxt  = step_r + ONE_STEP;
                  acc_step  = step_nxt;
                  we_nxt    = acc_we;
                  addr_nxt  = acc_addr;
                  wdata_nxt = acc_wdata;
               end
               else
               begin
                  state_nxt = ST_IDLE;
                  busy_nxt  = 1'b0;
                  req_nxt   = 1'b0;
                  we_nxt    = 1'b0;
                  done_nxt  = 1'b1;
                  unique case (op_r)
                     OP_MEM_PUSH:
                     begin
                        s_nxt  = s_r + {12'h000, mem_steps(op_r, opnd_r)};        // [R5]
                        rp_nxt = opnd_r[OPND_RP_HI:OPND_RP_LO];                   // [R5]
                     end
                     OP_MEM_POP:
                     begin
                        s_nxt  = s_r - {12'h000, mem_steps(op_r, opnd_r)};
                        rp_nxt = opnd_r[OPND_RP_HI:OPND_RP_LO];                   // [R7]
                     end
                     OP_MEMORY_STORE:
                        rp_nxt = rp_r - 3'h1;                          // [R8]
                     OP_PROCEDURE_CALL:
                     begin
                        l_nxt  = s_r + MARKER_WORDS;                   // [R18] [R10]
                        s_nxt  = s_r + MARKER_WORDS;                   // [R18]
                        p_nxt  = opnd_r;
                        rp_nxt = RP_EMPTY;                             // [R1]
                     end
                     OP_PROC_EXIT:
                     begin
                        // register stack untouched so a result stays on top
                        s_nxt = l_r - opnd_r;                          // [R4] [R19]
                        l_nxt = I_MEM_RDATA;                           // [R19] [R10]
                        p_nxt = tmp_p_r;
                     end
                     OP_SUBPROC_BRANCH:
                     begin
                        s_nxt = s_r + ONE_WORD;                        // [R11]
                        p_nxt = p_r - ONE_WORD + opnd_r;               // [R12]
                     end
                     OP_SUBPROC_RETURN:
                     begin
                        // a zero decrement would leave the return address behind
                        p_nxt = I_MEM_RDATA;                           // [R13]
                        s_nxt = s_r - opnd_r;                          // [R13] [R14]
                     end
                     default:
                        p_nxt = p_r;
                  endcase
               end
            end
         end
         default:
            state_nxt = ST_IDLE;
      endcase
      // top of stack registered together with the pointer
      top_nxt   = regs_nxt[rp_nxt];
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge I_REF_CLK)
   begin
      if (!I_RST_N)
      begin
         state_r <= ST_IDLE;
         op_r    <= OP_NOP;
         opnd_r  <= 16'h0000;
         step_r  <= 4'h0;
         for (int i = 0; i < RS_DEPTH; i++)
            regs_r[i] <= 16'h0000;
         rp_r    <= RP_EMPTY;                                          // [R1]
         l_r     <= 16'h0000;
         s_r     <= 16'h0000;
         p_r     <= 16'h0000;
         env_r   <= 16'h0000;
         tmp_p_r <= 16'h0000;
         top_r   <= 16'h0000;
         busy_r  <= 1'b0;
         done_r  <= 1'b0;
         req_r   <= 1'b0;
         we_r    <= 1'b0;
         addr_r  <= 16'h0000;
         wdata_r <= 16'h0000;
         cmap_r  <= MAP_USER_CODE;
         dmap_r  <= MAP_USER_DATA;
      end
      else
      begin
         state_r <= state_nxt;
         op_r    <= op_nxt;
         opnd_r  <= opnd_nxt;
         step_r  <= step_nxt;
         regs_r  <= regs_nxt;
         rp_r    <= rp_nxt;
         l_r     <= l_nxt;
         s_r     <= s_nxt;
         p_r     <= p_nxt;
         env_r   <= env_nxt;
         tmp_p_r <= tmp_p_nxt;
         top_r   <= top_nxt;
         busy_r  <= busy_nxt;
         done_r  <= done_nxt;
         req_r   <= req_nxt;
         we_r    <= we_nxt;
         addr_r  <= addr_nxt;
         wdata_r <= wdata_nxt;
         cmap_r  <= cmap_nxt;
         dmap_r  <= dmap_nxt;
      end
   end

   // outputs straight from flops
   assign O_BUSY      = busy_r;
   assign O_DONE      = done_r;
   assign O_MEM_REQ   = req_r;
   assign O_MEM_WE    = we_r;
   assign O_MEM_ADDR  = addr_r;
   assign O_MEM_WDATA = wdata_r;
   assign O_RP        = rp_r;
   assign O_TOP       = top_r;
   assign O_L         = l_r;
   assign O_S         = s_r;
   assign O_P         = p_r;
   assign O_ENV       = env_r;
   assign O_CODE_MAP  = cmap_r;
   assign O_DATA_MAP  = dmap_r;

endmodule

/* File: tb/pcsu_properties.sv */
// concurrent checks on the ports of the procedure call stack unit
`timescale 1ns/1ps

module pcsu_properties
(
   input wire logic               I_REF_CLK,
   input wire logic               I_RST_N,
   input wire logic               I_OP_VALID,
   input wire pcsu_pkg::pcsu_op_t I_OP,
   input wire logic [15:0]        I_OPERAND,
   input wire logic               I_LS,
   input wire logic               I_CS,
   input wire logic               I_DS,
   input wire logic               I_MEM_ACK,
   input wire logic               O_BUSY,
   input wire logic               O_DONE,
   input wire logic               O_MEM_REQ,
   input wire logic               O_MEM_WE,
   input wire logic [15:0]        O_MEM_ADDR,
   input wire logic [15:0]        O_MEM_WDATA,
   input wire logic [2:0]         O_RP,
   input wire logic [15:0]        O_TOP,
   input wire logic [15:0]        O_L,
   input wire logic [15:0]        O_S,
   input wire logic [15:0]        O_P,
   input wire logic [2:0]         O_CODE_MAP,
   input wire logic [2:0]         O_DATA_MAP
);
   import pcsu_pkg::*;
   pcsu_op_t   last_op_r;
   wire logic  take = I_OP_VALID && !O_BUSY;

   // remembers the op in flight, so its completion is judged by kind
   always_ff @(posedge I_REF_CLK)
   begin
      if (!I_RST_N)
         last_op_r <= OP_NOP;
      else if (take)
         last_op_r <= I_OP;
   end

   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RST_N);

   // ***************************************************************
   // checks
   // ***************************************************************
   AST_LDI_PUSH: assert property (take && I_OP == OP_LOAD_IMMEDIATE |=> O_DONE
      && O_RP == $past(O_RP) + 3'h1 && O_TOP == $past(I_OPERAND))
      else $error("load immediate did not advance the pointer");
   AST_MUL_DROP: assert property (take && I_OP == OP_INTEGER_MULTIPLY |=>
      O_DONE && O_RP == $past(O_RP) - 3'h1)
      else $error("multiply did not pull the pointer back");
   AST_PUSH_FIRST: assert property (take && I_OP == OP_MEM_PUSH |=>
      O_MEM_REQ && O_MEM_WE && O_MEM_ADDR == $past(O_S) + 16'h0001)
      else $error("push did not write above the stack top");
   AST_CALL_MARK: assert property (take && I_OP == OP_PROCEDURE_CALL |=>
      O_MEM_WE && O_MEM_ADDR == $past(O_S) + 16'h0001 && O_MEM_WDATA == $past(O_P))
      else $error("call marker not started above the stack top");
   AST_CALL_DONE: assert property (O_DONE && last_op_r == OP_PROCEDURE_CALL |->
      O_RP == RP_EMPTY && O_L == O_S)
      else $error("called procedure did not start clean");
   AST_SUBPROC_BRANCH_OP_SAVE: assert property (take && I_OP == OP_SUBPROC_BRANCH |=>
      O_MEM_WE && O_MEM_ADDR == $past(O_S) + 16'h0001 && O_MEM_WDATA == $past(O_P))
      else $error("branch did not save the return address");
   AST_SUBPROC_RETURN_OP_READ: assert property (take && I_OP == OP_SUBPROC_RETURN |=>
      O_MEM_REQ && !O_MEM_WE && O_MEM_ADDR == $past(O_S))
      else $error("return did not read the stack top");
   AST_SMINUS: assert property (take && I_OP == OP_MEM_LOAD
      && I_OPERAND[6:5] == MODE_S_MINUS |=> O_MEM_ADDR == $past(O_S) - {11'h000,
      $past(I_OPERAND[4:0])})
      else $error("stack relative address wrong");
   AST_REQ_HOLD: assert property (O_MEM_REQ && !I_MEM_ACK |=>
      O_MEM_REQ && $stable(O_MEM_ADDR) && $stable(O_MEM_WE) && $stable(O_MEM_WDATA))
      else $error("memory request changed before its ack");
   AST_CODE_MAP: assert property (1'b1 |=> O_CODE_MAP ==
      MAP_USER_CODE + {1'b0, $past(I_LS), $past(I_CS)})
      else $error("code map number wrong");
   AST_DATA_MAP: assert property (1'b1 |=>
      O_DATA_MAP == ($past(I_DS) ? MAP_SYS_DATA : MAP_USER_DATA))
      else $error("data map number wrong");
endmodule

bind pcsu_stack_unit pcsu_properties u_pcsu_properties
(
   .I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_OP_VALID(I_OP_VALID), .I_OP(I_OP),
   .I_OPERAND(I_OPERAND), .I_LS(I_LS), .I_CS(I_CS), .I_DS(I_DS), .I_MEM_ACK(I_MEM_ACK),
   .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_MEM_REQ(O_MEM_REQ), .O_MEM_WE(O_MEM_WE),
   .O_MEM_ADDR(O_MEM_ADDR), .O_MEM_WDATA(O_MEM_WDATA), .O_RP(O_RP), .O_TOP(O_TOP),
   .O_L(O_L), .O_S(O_S), .O_P(O_P), .O_CODE_MAP(O_CODE_MAP), .O_DATA_MAP(O_DATA_MAP)
);

/* File: tb/tb.sv */
// self-checking testbench for the procedure call stack unit
`timescale 1ns/1ps

module tb;
   import pcsu_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        op_valid = 1'b0;
   pcsu_op_t    op = OP_NOP;
   logic [15:0] operand = 16'h0000;
   logic [15:0] env = 16'h0000;
   logic        ls = 1'b0;
   logic        cs = 1'b0;
   logic        ds = 1'b0;
   logic        ack = 1'b0;
   logic        slow = 1'b0;
   logic        tog = 1'b0;
   logic [15:0] rdata = 16'h0000;
   logic        busy, done, req, we;
   logic [15:0] addr, wdata, top, l, s, p, env_o;
   logic [2:0]  rp, cmap, dmap;
   logic [15:0] mem [0:255];
   int          fails = 0;
   int          n_tests = 0;
   int          cyc = 0;

   pcsu_stack_unit u_pcsu_stack_unit
   (
      .I_REF_CLK(clk), .I_RST_N(rst_n), .I_OP_VALID(op_valid), .I_OP(op),
      .I_OPERAND(operand), .I_ENV(env), .I_LS(ls), .I_CS(cs), .I_DS(ds),
      .I_MEM_ACK(ack), .I_MEM_RDATA(rdata), .O_BUSY(busy), .O_DONE(done),
      .O_MEM_REQ(req), .O_MEM_WE(we), .O_MEM_ADDR(addr), .O_MEM_WDATA(wdata),
      .O_RP(rp), .O_TOP(top), .O_L(l), .O_S(s), .O_P(p), .O_ENV(env_o),
      .O_CODE_MAP(cmap), .O_DATA_MAP(dmap)
   );

   initial
      forever #2.5 clk = ~clk;

   // ***************************************************************
   // memory side
   // ***************************************************************
   // slow mode acks every other cycle; a released read bus shows inverted data
   always @(posedge clk)
   begin
      if (ack && we)
         mem[addr[7:0]] <= wdata;
      #1;
      tog = ~tog;
      ack = req && (!slow || tog);
      rdata = (req && !we) ? mem[addr[7:0]] : ~rdata;
   end

   // hang guard, well above the hundred-odd cycles the tests need
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         fails++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one op, then a bounded wait for its completion pulse
   task automatic run(input pcsu_op_t o, input logic [15:0] v);
      int i;
      @(posedge clk);
      #1;
      op_valid = 1'b1;
      op = o;
      operand = v;
      @(posedge clk);
      #1;
      op_valid = 1'b0;
      chk(16'(busy), 16'(o >= OP_MEM_LOAD));
      for (i = 0; i < 50 && done !== 1'b1; i++)
         @(posedge clk) #1;
      chk(16'(done), 16'h0001);
   endtask

   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_maps();
      for (int k = 0; k < 8; k++)
      begin
         @(posedge clk);
         #1;
         {ls, cs, ds} = k[2:0];
         @(posedge clk);
         #1;
         chk(16'(cmap), 16'(MAP_USER_CODE + {1'b0, ls, cs}));
         chk(16'(dmap), 16'(ds ? MAP_SYS_DATA : MAP_USER_DATA));
      end
      {ls, cs, ds} = 3'h0;
   endtask

   // value return through the register stack inside an outer procedure
   task automatic t_return();
      env = 16'h0011;
      run(OP_PROCEDURE_CALL, 16'h0040);
      run(OP_LOAD_IMMEDIATE, 16'h0011);
      chk(16'(rp), 16'h0000);
      run(OP_LOAD_IMMEDIATE, 16'h0022);
      chk(16'(rp), 16'h0001);
      run(OP_INTEGER_ADD, 16'h0000);
      run(OP_LOAD_IMMEDIATE, 16'h0005);
      run(OP_MEM_PUSH, 16'h01c9);
      chk(mem[4], 16'h0033);
      chk(mem[5], 16'h0005);
      chk(16'(rp), 16'h0007);
      chk(s, 16'h0005);
      env = 16'h00a5;
      slow = 1'b1;
      run(OP_PROCEDURE_CALL, 16'h0100);
      chk(mem[6], 16'h0040);
      chk(mem[7], 16'h00a5);
      chk(mem[8], 16'h0003);
      chk(l, 16'h0008);
      chk(s, 16'h0008);
      chk(16'(rp), 16'h0007);
      run(OP_MEM_LOAD, 16'h0023);
      run(OP_MEM_LOAD, 16'h0023);
      chk(top, 16'h0005);
      run(OP_INTEGER_MULTIPLY, 16'h0000);
      chk(top, 16'h0019);
      chk(16'(rp), 16'h0000);
      run(OP_PROC_EXIT, 16'h0004);
      chk(s, 16'h0004);
      chk(l, 16'h0003);
      chk(p, 16'h0040);
      chk(env_o, 16'h00a5);
      chk(top, 16'h0019);
      slow = 1'b0;
      run(OP_REGSTACK_MOVE, 16'h0001);
      run(OP_MEM_POP, 16'h0040);
      chk(16'(rp), 16'h0001);
      chk(top, 16'h0019);
      chk(s, 16'h0003);
      run(OP_INTEGER_SUBTRACT, 16'h0000);
      run(OP_MEMORY_STORE, 16'h0003);
      chk(mem[6], 16'h001a);
      chk(16'(rp), 16'h0007);
      run(OP_PROC_EXIT, 16'h0003);
      chk(l, 16'h0000);
      chk(env_o, 16'h0011);
   endtask

   // subprocedure branch, sublocal reach at both ends, return
   task automatic t_sub();
      env = 16'h0000;
      mem[8'he5] = 16'h5a5a;
      run(OP_PROCEDURE_CALL, 16'h0200);
      run(OP_SUBPROC_BRANCH, 16'h0010);
      run(OP_NOP, 16'hffff);
      chk(mem[4], 16'h0200);
      chk(s, 16'h0004);
      chk(p, 16'h020f);
      run(OP_MEM_LOAD, 16'h0040);
      chk(top, 16'h0200);
      run(OP_MEM_LOAD, 16'h005f);
      chk(top, 16'h5a5a);
      run(OP_SUBPROC_RETURN, 16'h0001);
      chk(p, 16'h0200);
      chk(s, 16'h0003);
      run(OP_PROC_EXIT, 16'h0003);
   endtask

   task automatic tally_and_finish();
      if (fails == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (16) @(posedge clk);
      #1;
      rst_n = 1'b1;
      chk(16'(rp), 16'h0007);
      chk(s, 16'h0000);
      t_maps();
      t_return();
      t_sub();
      tally_and_finish();
   end
endmodule
